// *** bench/tb.sv ***
`timescale 1ns/1ps
// bench: page, poll and guard cases, then device word table, wrap and second reset
module tb;
  typedef struct packed {
    logic [7:0] dev;
    logic ack;
  } tes_row_s;
  localparam longint PROG = 200;
  localparam logic [7:0] DEVR = 8'ha5;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic writeGuard = 1'b0;
  logic strapSelectLow = 1'b0;
  logic strapSelectHigh = 1'b1;
  logic scl, hostPull, sdaOut, sdaOe, standby, programBusy, ack;
  logic [7:0] d;
  int fails = 0;
  int total_checks = 0;
  wire logic sdaWire = ~(sdaOe | hostPull); // pull-up wins unless someone pulls
  tes_row_s rows [8] = '{'{8'ha5, 1'b1}, '{8'ha4, 1'b1}, '{8'ha0, 1'b0}, '{8'ha6, 1'b0},
    '{8'ha2, 1'b0}, '{8'h24, 1'b0}, '{8'ha1, 1'b0}, '{8'he4, 1'b0}};
  // 40 MHz clock
  always #12.5 clock = ~clock;
  tes_eeprom_slave #(.PROG_CYCLES(PROG)) tes_eeprom_slave_inst (.clock(clock), .rst_n(rst_n),
    .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelectLow(strapSelectLow),
    .strapSelectHigh(strapSelectHigh), .writeGuard(writeGuard), .standby(standby), .programBusy(programBusy));
  tes_host_model tes_host_model_inst (.clock(clock), .sdaWire(sdaWire), .scl(scl), .sdaPull(hostPull));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic waitIdle;
    for (int i = 0; i < 400 && programBusy !== 1'b0; i++) @(posedge clock);
    @(posedge clock); // standby flop follows the timer by one clock
  endtask : waitIdle
  task automatic readAt(input logic [15:0] a);
    tes_host_model_inst.point(a, ack);
    check("pointAck", ack, 1'b1);
    tes_host_model_inst.start();
    tes_host_model_inst.wbyte(DEVR, ack);
    check("readAck", ack, 1'b1);
  endtask : readAt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("standby", standby, 1'b1);
    check("busy", programBusy, 1'b0);
    $display("test power-up done");
    tes_host_model_inst.recover();
    tes_host_model_inst.point(16'h127f, ack);
    check("pointAck", ack, 1'b1);
    for (int i = 0; i < 4; i++) begin
      tes_host_model_inst.wbyte(8'h60 + 8'(i), ack);
      check("dataAck", ack, 1'b1);
    end
    tes_host_model_inst.stop();
    repeat (8) @(posedge clock);
    check("busy", programBusy, 1'b1);
    tes_host_model_inst.start();
    tes_host_model_inst.wbyte(8'ha4, ack);
    check("pollAck", ack, 1'b0);
    tes_host_model_inst.stop();
    waitIdle();
    check("idle", standby, 1'b1);
    readAt(16'h1200);
    for (int i = 1; i < 4; i++) begin
      if (i == 2) begin
        tes_host_model_inst.stop();
        tes_host_model_inst.start();
        tes_host_model_inst.wbyte(DEVR, ack);
      end
      tes_host_model_inst.rbyte(i == 2, d);
      check("readData", d, 8'h60 + 8'(i));
    end
    tes_host_model_inst.stop();
    $display("test page done");
    writeGuard <= 1'b1;
    tes_host_model_inst.point(16'h1200, ack);
    tes_host_model_inst.wbyte(8'h5a, ack);
    tes_host_model_inst.stop();
    repeat (8) @(posedge clock);
    check("guardBusy", programBusy, 1'b0);
    writeGuard <= 1'b0;
    readAt(16'h1200);
    tes_host_model_inst.rbyte(1'b0, d);
    check("guardData", d, 8'h61);
    tes_host_model_inst.stop();
    $display("test guard done");
    foreach (rows[i]) begin
      tes_host_model_inst.start();
      tes_host_model_inst.wbyte(rows[i].dev, ack);
      check("devAck", ack, rows[i].ack);
      repeat (6) @(posedge clock);
      check("devStandby", standby, !rows[i].ack);
      if (ack && rows[i].dev[0]) tes_host_model_inst.rbyte(1'b0, d);
      tes_host_model_inst.stop();
    end
    $display("test address done");
    for (int i = 0; i < 2; i++) begin
      tes_host_model_inst.point((i == 1) ? 16'h0000 : 16'hffff, ack);
      tes_host_model_inst.wbyte((i == 1) ? 8'h3c : 8'hc3, ack);
      tes_host_model_inst.stop();
      waitIdle();
    end
    readAt(16'hffff);
    tes_host_model_inst.rbyte(1'b1, d);
    check("endData", d, 8'hc3);
    tes_host_model_inst.rbyte(1'b0, d);
    check("wrapData", d, 8'h3c);
    tes_host_model_inst.stop();
    $display("test wrap done");
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("rstStandby", standby, 1'b1);
    tes_host_model_inst.start();
    tes_host_model_inst.wbyte(DEVR, ack);
    check("rstAck", ack, 1'b1);
    tes_host_model_inst.rbyte(1'b0, d);
    check("rstData", d, 8'h3c);
    tes_host_model_inst.stop();
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb

// *** bench/tes_eeprom_slave_properties.sv ***
`timescale 1ns/1ps
// pin checker; latencies follow the sync chain of the slave
module tes_eeprom_slave_properties #(
  parameter longint PROG_CYCLES = tes_pkg::PROG_CYCLES_STD
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // straps and guard
  input wire logic strapSelectLow,
  input wire logic strapSelectHigh,
  input wire logic writeGuard,
  // status
  input wire logic standby,
  input wire logic programBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [19:0] busyCnt_r;
  wire logic [19:0] busyCnt_nxt = programBusy ? busyCnt_r + 20'h00001 : 20'h00000;
  // busy length counter, cleared by reset so a second reset starts clean
  always_ff @(posedge clock) begin
    busyCnt_r <= rst_n ? busyCnt_nxt : 20'h00000;
  end
  property p_drive_low; sdaOe |-> sdaOut == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda drive value not low");
  property p_reset_idle; $rose(rst_n) |-> standby && !programBusy && !sdaOe; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  property p_busy_standby; programBusy |-> !standby; endproperty
  a_busy_standby: assert property (p_busy_standby) else $error("standby while busy");
  property p_busy_len; $fell(programBusy) |-> busyCnt_r == 20'(PROG_CYCLES); endproperty
  a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
  property p_busy_quiet; programBusy |-> !sdaOe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("sda driven while busy");
  property p_change_low; $changed(sdaOe) |-> !$past(scl, 3); endproperty
  a_change_low: assert property (p_change_low) else $error("sda moved outside clock low");
  property p_ack_hold; $rose(sdaOe) |-> sdaOe [*7]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda low too short");
  property p_busy_cause; $rose(programBusy) |-> !writeGuard && $past(scl) && $past(sdaIn); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("program cycle without stop");
endmodule : tes_eeprom_slave_properties

bind tes_eeprom_slave tes_eeprom_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) tes_eeprom_slave_properties_inst (
  .clock(clock), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .strapSelectLow(strapSelectLow), .strapSelectHigh(strapSelectHigh), .writeGuard(writeGuard),
  .standby(standby), .programBusy(programBusy));

// *** bench/tes_host_model.sv ***
`timescale 1ns/1ps
// host master, one bit per 8 clocks; scl stands high between frames
module tes_host_model (
  // clock
  input wire logic clock,
  // bus
  input wire logic sdaWire,
  output logic scl,
  output logic sdaPull
);
  logic r;
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // data moves only in the low phase, sampled late in the high phase
  // the bit time is fixed by the bench; a real host keeps the grade's rate
  task automatic xbit(input logic b, output logic s);
    scl <= 1'b0;
    @(posedge clock);
    sdaPull <= ~b;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    repeat (3) @(posedge clock);
    s = sdaWire;
    @(posedge clock);
  endtask : xbit
  task automatic start;
    xbit(1'b1, r);
    sdaPull <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : start
  task automatic stop;
    xbit(1'b0, r);
    sdaPull <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : stop
  task automatic recover;
    repeat (9) xbit(1'b1, r);
  endtask : recover
  task automatic wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(v[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) xbit(1'b1, v[i]);
    xbit(~more, r);
  endtask : rbyte
  // dummy write that loads the counter, high address byte first
  task automatic point(input logic [15:0] a, output logic ack);
    logic a1;
    logic a2;
    start();
    wbyte(8'ha4, ack);
    wbyte(a[15:8], a1);
    wbyte(a[7:0], a2);
    ack = ack & a1 & a2;
  endtask : point
endmodule : tes_host_model

// *** design/tes_eeprom_slave.sv ***
`timescale 1ns/1ps
module tes_eeprom_slave #(
  parameter longint PROG_CYCLES = tes_pkg::PROG_CYCLES_STD
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // two-wire bus, sda is open drain
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // strap pins and write guard
  input wire logic strapSelectLow,
  input wire logic strapSelectHigh,
  input wire logic writeGuard,
  // status
  output logic standby,
  output logic programBusy
);

  localparam logic [tes_pkg::PROG_CNT_W-1:0] PROG_LOAD = tes_pkg::PROG_CNT_W'(PROG_CYCLES);

  // pin synchronisers
  logic [tes_pkg::SYNC_W-1:0] pinRaw;
  logic [tes_pkg::SYNC_W-1:0] meta_r;
  logic [tes_pkg::SYNC_W-1:0] sync_r;
  logic sclP_r;
  logic sdaP_r;

  // protocol state
  tes_pkg::tes_state_e state_r;
  tes_pkg::tes_state_e stateNxt;
  logic [3:0] bitCnt_r;
  logic [3:0] bitCntNxt;
  logic [7:0] rxSh_r;
  logic [7:0] rxShNxt;
  logic [7:0] txSh_r;
  logic [7:0] txShNxt;
  logic sdaOe_r;
  logic sdaOeNxt;
  logic txPhase_r;
  logic txPhaseNxt;
  logic [tes_pkg::ADDR_W-1:0] addrCnt_r;
  logic [tes_pkg::ADDR_W-1:0] addrCntNxt;
  logic [7:0] addrHi_r;
  logic [7:0] addrHiNxt;
  logic dataSeen_r;
  logic dataSeenNxt;
  logic [tes_pkg::PROG_CNT_W-1:0] progCnt_r;
  logic standby_r;
  logic memWe;
  logic [tes_pkg::DATA_W-1:0] memRdata;

  // compare a device address word against type pattern and straps
  function automatic logic dev_match(input logic [7:0] word, input logic hi, input logic lo);
    logic typeOk;
    typeOk = (word[7:tes_pkg::DEV_TYPE_LSB] == tes_pkg::DEV_TYPE);
    return typeOk & (word[tes_pkg::DEV_STRAP_HI_POS] == hi) & (word[tes_pkg::DEV_STRAP_LO_POS] == lo);
  endfunction : dev_match

  // decoded bus events
  wire sclS = sync_r[0];
  wire sdaS = sync_r[1];
  wire strapLoS = sync_r[2];
  wire strapHiS = sync_r[3];
  wire guardS = sync_r[4];

  // previous levels reset to the idle high, so leaving reset never
  // looks like a falling clock or a start
  wire sclRise = sclS & ~sclP_r;
  wire sclFall = ~sclS & sclP_r;
  wire startSeen = sclS & sclP_r & sdaP_r & ~sdaS;
  wire stopSeen = sclS & sclP_r & ~sdaP_r & sdaS;

  // timer status; only a stop that closes a written data phase starts it
  wire progBusy = (progCnt_r != tes_pkg::PROG_CNT_RESET);
  wire progStart = stopSeen & (state_r == tes_pkg::ST_WDATA) & dataSeen_r;

  // write step keeps the page bits and wraps the offset
  wire [tes_pkg::ADDR_W-1:0] pageNext = {addrCnt_r[tes_pkg::ADDR_W-1:tes_pkg::PAGE_OFS_W],
                                         addrCnt_r[tes_pkg::PAGE_OFS_W-1:0] + 7'h01};

  // a device word is refused while the program cycle runs
  wire devHit = dev_match(rxSh_r, strapHiS, strapLoS) & ~progBusy;

  assign pinRaw = {writeGuard, strapSelectHigh, strapSelectLow, sdaIn, scl};

  // two flops per pin; only the second flop is looked at by logic
  // straps and guard are static in use, yet still cross the clock boundary
  genvar gi;
  generate
    for (gi = 0; gi < tes_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          meta_r[gi] <= tes_pkg::SYNC_RESET[gi];
          sync_r[gi] <= tes_pkg::SYNC_RESET[gi];
        end else begin
          meta_r[gi] <= pinRaw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  // previous sampled levels for edge and start/stop detection
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
    end else begin
      sclP_r <= sclS;
      sdaP_r <= sdaS;
    end
  end

  // protocol engine: start and stop outrank clock edges
  always_comb begin
    stateNxt = state_r;
    bitCntNxt = bitCnt_r;
    rxShNxt = rxSh_r;
    txShNxt = txSh_r;
    sdaOeNxt = sdaOe_r;
    txPhaseNxt = txPhase_r;
    addrCntNxt = addrCnt_r;
    addrHiNxt = addrHi_r;
    dataSeenNxt = dataSeen_r;
    memWe = 1'b0;
    if (startSeen) begin
      // a start restarts the frame from any state
      stateNxt = tes_pkg::ST_DEVADR;
      bitCntNxt = tes_pkg::BIT_FIRST;
      sdaOeNxt = 1'b0;
      txPhaseNxt = 1'b0;
      dataSeenNxt = 1'b0;
    end else if (stopSeen) begin
      // stop releases the bus and drops to standby
      stateNxt = tes_pkg::ST_IDLE;
      sdaOeNxt = 1'b0;
      txPhaseNxt = 1'b0;
    end else if (state_r != tes_pkg::ST_IDLE) begin
      if (sclRise) begin
        if (bitCnt_r < tes_pkg::BIT_LAST) begin
          // sample on rising scl, msb arrives first
          rxShNxt = {rxSh_r[6:0], sdaS};
          bitCntNxt = bitCnt_r + 4'h1;
        end else if (bitCnt_r == tes_pkg::BIT_ACK && txPhase_r) begin
          // byte sent: counter moves on, wrapping at the array end
          addrCntNxt = addrCnt_r + 16'h0001;
          if (sdaS) begin
            stateNxt = tes_pkg::ST_IDLE; // host nack ends the read
          end
        end
      end else if (sclFall) begin
        if (bitCnt_r == tes_pkg::BIT_LAST) begin
          bitCntNxt = tes_pkg::BIT_ACK;
          sdaOeNxt = 1'b0; // after a sent byte, release for the host ack
          if (!txPhase_r) begin
            sdaOeNxt = 1'b1; // acknowledge each received word except a device word that misses
            case (state_r)
              tes_pkg::ST_DEVADR: begin
                if (devHit) begin
                  // match acked; lsb picks read or write
                  stateNxt = rxSh_r[tes_pkg::DEV_RW_POS] ? tes_pkg::ST_RDATA : tes_pkg::ST_ADRHI;
                end else begin
                  sdaOeNxt = 1'b0; // no ack, back to standby
                  stateNxt = tes_pkg::ST_IDLE;
                end
              end
              tes_pkg::ST_ADRHI: begin
                addrHiNxt = rxSh_r; // high half of the address first
                stateNxt = tes_pkg::ST_ADRLO;
              end
              tes_pkg::ST_ADRLO: begin
                // full address loaded; a read may now follow a repeated start
                addrCntNxt = {addrHi_r, rxSh_r};
                stateNxt = tes_pkg::ST_WDATA;
              end
              tes_pkg::ST_WDATA: begin
                // store unless guarded; page offset wraps inside the page
                memWe = ~guardS;
                addrCntNxt = pageNext;
                dataSeenNxt = dataSeen_r | ~guardS;
              end
              default: begin
                sdaOeNxt = 1'b0;
              end
            endcase
          end
        end else if (bitCnt_r == tes_pkg::BIT_ACK) begin
          bitCntNxt = tes_pkg::BIT_FIRST;
          sdaOeNxt = 1'b0;
          txPhaseNxt = 1'b0;
          if (state_r == tes_pkg::ST_RDATA) begin
            // load the byte at the counter, drive its msb after the fall
            txShNxt = memRdata;
            sdaOeNxt = ~memRdata[7];
            txPhaseNxt = 1'b1;
          end
        end else if (txPhase_r) begin
          // next bit goes out after each falling scl
          txShNxt = {txSh_r[6:0], 1'b0};
          sdaOeNxt = ~txSh_r[6];
        end
      end
    end
  end

  // protocol registers; counter survives operations, cleared only by reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= tes_pkg::ST_IDLE;
      bitCnt_r <= tes_pkg::BIT_FIRST;
      rxSh_r <= 8'h00;
      txSh_r <= 8'h00;
      sdaOe_r <= 1'b0;
      txPhase_r <= 1'b0;
      addrCnt_r <= tes_pkg::ADDR_RESET;
      addrHi_r <= 8'h00;
      dataSeen_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      bitCnt_r <= bitCntNxt;
      rxSh_r <= rxShNxt;
      txSh_r <= txShNxt;
      sdaOe_r <= sdaOeNxt;
      txPhase_r <= txPhaseNxt;
      addrCnt_r <= addrCntNxt;
      addrHi_r <= addrHiNxt;
      dataSeen_r <= dataSeenNxt;
    end
  end

  // program cycle timer; a guarded write never starts one
  // it cannot restart itself: the device word that opens a write is refused while busy
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      progCnt_r <= tes_pkg::PROG_CNT_RESET;
    end else if (progStart) begin
      progCnt_r <= PROG_LOAD;
    end else if (progBusy) begin
      progCnt_r <= progCnt_r - 20'h00001;
    end
  end

  // standby once idle and no program cycle pending
  // a read ended by a host nack is already idle here, ahead of its stop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= (stateNxt == tes_pkg::ST_IDLE) & ~progBusy & ~progStart;
    end
  end

  // array; bytes land as they are acked, so an aborted page keeps them
  // read data lag the counter by one clock, well inside the four clocks
  // between a counter step and the fall that loads the next byte
  tes_mem_array u_array (
    .clock(clock),
    .wrEn(memWe),
    .wrAddr(addrCnt_r),
    .wrData(rxSh_r),
    .rdAddr(addrCnt_r),
    .rdData(memRdata)
  );

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_r;

  // status: standby from its flop, busy from the timer compare
  assign standby = standby_r;
  assign programBusy = progBusy;

endmodule : tes_eeprom_slave

// *** design/tes_mem_array.sv ***
`timescale 1ns/1ps
// byte array with one write port and a registered read port
module tes_mem_array (
  // clock
  input wire logic clock,
  // write port
  input wire logic wrEn,
  input wire logic [tes_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [tes_pkg::DATA_W-1:0] wrData,
  // read port, data one cycle after the address
  input wire logic [tes_pkg::ADDR_W-1:0] rdAddr,
  output logic [tes_pkg::DATA_W-1:0] rdData
);

  logic [tes_pkg::DATA_W-1:0] cells [0:tes_pkg::MEM_DEPTH-1];

  // no reset on the array: contents are what was last programmed
  always_ff @(posedge clock) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    rdData <= cells[rdAddr];
  end

endmodule : tes_mem_array

// *** design/tes_pkg.sv ***
// shared constants of the two-wire serial memory slave
package tes_pkg;

  // array geometry: 512 pages of 128 bytes, 16-bit word address
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 65536;
  localparam int PAGE_OFS_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

  // device address word: fixed type pattern in the five upper bits
  localparam logic [4:0] DEV_TYPE = 5'h14;
  localparam int DEV_RW_POS = 0;
  localparam int DEV_STRAP_LO_POS = 1;
  localparam int DEV_STRAP_HI_POS = 2;
  localparam int DEV_TYPE_LSB = 3;

  // bit counter milestones inside one nine-clock word
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  // pins that cross into the clock domain: scl, sda, straps, guard
  localparam int SYNC_W = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h03;

  // program cycle time, longest figure per grade, and its cycle count
  localparam longint CLK_HZ = 40000000;
  localparam longint PROG_TIME_STD_MS = 10;
  localparam longint PROG_TIME_LV_MS = 20;
  localparam longint PROG_CYCLES_STD = (PROG_TIME_STD_MS * CLK_HZ) / 1000;
  localparam longint PROG_CYCLES_LV = (PROG_TIME_LV_MS * CLK_HZ) / 1000;
  localparam int PROG_CNT_W = 20;
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_RESET = 20'h00000;

  // highest serial clock rate the host may use, per grade
  localparam int BUS_CLOCK_RATE_LV_KHZ = 100;
  localparam int BUS_CLOCK_RATE_MID_KHZ = 400;
  localparam int BUS_CLOCK_RATE_STD_KHZ = 1000;

  // protocol states, gray coded along standby, address, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADR = 3'h1,
    ST_ADRHI = 3'h3,
    ST_ADRLO = 3'h2,
    ST_WDATA = 3'h6,
    ST_RDATA = 3'h7
  } tes_state_e;

endpackage : tes_pkg
